// File: htpc_pkg.sv
// Functional notes
// - writing launch flag high starts playback except in level mode, where the trigger overrides writes; clearing it early aborts playback
// - edge mode: trigger rising edge sets launch flag, sequence plays
// - edge mode: rising edge while flag high cancels playback, clears flag
// - edge mode: trigger falling edge does nothing
// - level mode: launch flag follows trigger; falling edge aborts playback
// - noise gate suppresses input amplitude below two-bit threshold
// - supply voltage field updates during playback, readable by host
// - bus watchdog resets protocol after 4.33 ms stall, not in standby
// - overtemperature shuts down and sets status flag
// - output short during playback latches short flag, shuts down, restarts default when cleared
// - regulator short keeps device dead, returns to defaults on removal
// - brownout issues internal reset; restart in default state
// - enable high is active; low is shutdown keeping registers
// - enable low: no register read or write happens
// - standby bit resets set; low power keeps registers and bus
// - setting standby stops playback at once; clearing goes ready
// - software reset bit aborts playback, restores defaults, self-clears
// - launch flag stays high until sequence done; mirrors trigger in level mode, toggles on rising edge in edge mode
package htpc_pkg;
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] MODE_ADDR   = 8'h01;
  localparam logic [7:0] LAUNCH_ADDR = 8'h0c;
  localparam logic [7:0] CFG_ADDR    = 8'h1d;
  localparam logic [7:0] SUPPLY_ADDR = 8'h21;
  localparam int STAT_OVERTEMP_BIT = 1;
  localparam int STAT_SHORT_BIT    = 0;
  localparam int MODE_RESET_BIT    = 7;
  localparam int MODE_STANDBY_BIT  = 6;
  localparam logic [7:0] MODE_RESET_VAL = 8'h40;
  localparam logic [7:0] CFG_RESET_VAL  = 8'h00;
  localparam logic [2:0] TRIG_INTERNAL = 3'h0;
  localparam logic [2:0] TRIG_EDGE     = 3'h1;
  localparam logic [2:0] TRIG_LEVEL    = 3'h2;
  localparam int CLK_MHZ = 50;
  localparam int WDOG_US_X100 = 433000;
  localparam int WDOG_CYCLES = WDOG_US_X100 * CLK_MHZ / 100;
  typedef enum logic [1:0] {
    HTPC_IDLE    = 2'b00,
    HTPC_READY   = 2'b01,
    HTPC_PLAY    = 2'b11,
    HTPC_FAULT   = 2'b10
  } htpc_state_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } htpc_req_t;
  typedef struct packed {
    logic overtemp;
    logic out_short;
    logic reg_short;
    logic brownout;
  } htpc_fault_t;
endpackage

// File: htpc_trig_sync.sv
`timescale 1ns/10ps
`default_nettype none
module htpc_trig_sync (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // pin in, conditioned level and edges out
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  // first stage is read only by the second
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign level_o = sync_r;
  assign rise_o  = sync_r & ~prev_r;
  assign fall_o  = ~sync_r & prev_r;
endmodule // htpc_trig_sync
`default_nettype wire

// File: htpc_top.sv
`timescale 1ns/10ps
`default_nettype none
module htpc_top
  import htpc_pkg::*;
#(
  parameter int WDOG_LIMIT = WDOG_CYCLES
) (
  // clock and reset (reset covers power-on)
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // pins and analog front-end status
  input  wire logic        enable_pin_i,
  input  wire logic        trigger_input_pin_i,
  input  wire logic [2:0]  trig_mode_i,
  input  wire logic        overtemp_i,
  input  wire logic        out_short_i,
  input  wire logic        reg_short_i,
  input  wire logic        brownout_i,
  input  wire logic [7:0]  supply_meas_i,
  input  wire logic [7:0]  input_amp_i,
  input  wire logic        seq_done_i,
  input  wire logic        bus_activity_i,
  input  wire logic        bus_idle_i,
  // control outputs
  output logic             playing_o,
  output logic             shutdown_o,
  output logic             bus_proto_rst_o,
  output logic      [7:0]  gated_amp_o
);
  ////////////////////////////////////////////////////////////////////////////
  htpc_req_t   req;
  htpc_fault_t flt;
  htpc_state_t state_r;
  logic        trig_lvl;
  logic        trig_rise;
  logic        trig_fall;
  logic        launch_r;
  logic [7:0]  mode_r;
  logic [7:0]  cfg_r;
  logic [7:0]  supply_r;
  logic        overtemp_r;
  logic        short_fault_flag_r;
  logic        soft_rst_r;
  logic [22:0] wdog_r;
  logic        dead;
  logic        reg_wr;
  logic        reg_rd;
  logic        standby;
  logic [7:0]  gate_level;

  assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
  assign flt = '{overtemp: overtemp_i, out_short: out_short_i,
                 reg_short: reg_short_i, brownout: brownout_i};
  // regulator short and brownout both act as a held internal reset
  assign dead    = flt.reg_short | flt.brownout;
  assign reg_wr  = req.wr & enable_pin_i;
  assign reg_rd  = req.rd & enable_pin_i;
  assign standby = mode_r[MODE_STANDBY_BIT];

  htpc_trig_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (trigger_input_pin_i),
    .level_o   (trig_lvl),
    .rise_o    (trig_rise),
    .fall_o    (trig_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode register: standby and self-clearing soft reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= MODE_RESET_VAL;
    end else if (dead || soft_rst_r) begin
      mode_r <= MODE_RESET_VAL;
    end else if (reg_wr && req.addr == MODE_ADDR) begin
      mode_r <= req.wdata;
    end
  end
  // reset bit lives one cycle then clears once defaults are loaded
  assign soft_rst_r = mode_r[MODE_RESET_BIT];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_r <= CFG_RESET_VAL;
    end else if (dead || soft_rst_r) begin
      cfg_r <= CFG_RESET_VAL;
    end else if (reg_wr && req.addr == CFG_ADDR) begin
      cfg_r <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // launch flag
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      launch_r <= 1'b0;
    end else if (dead || soft_rst_r || standby || !enable_pin_i ||
                 state_r == HTPC_FAULT) begin
      launch_r <= 1'b0;
    end else if (trig_mode_i == TRIG_LEVEL) begin
      launch_r <= trig_lvl;
    end else if (trig_mode_i == TRIG_EDGE && trig_rise) begin
      launch_r <= ~launch_r;
    end else if (reg_wr && req.addr == LAUNCH_ADDR) begin
      launch_r <= req.wdata[0];
    end else if (launch_r && seq_done_i) begin
      launch_r <= 1'b0;
    end
    // falling edge in edge mode leaves the flag alone
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= HTPC_IDLE;
    end else if (dead || soft_rst_r) begin
      state_r <= HTPC_IDLE;
    end else begin
      case (state_r)
        HTPC_IDLE:  if (!standby && enable_pin_i) state_r <= HTPC_READY;
        HTPC_READY: begin
          if (flt.overtemp || flt.out_short) state_r <= HTPC_FAULT;
          else if (standby || !enable_pin_i) state_r <= HTPC_IDLE;
          else if (launch_r) state_r <= HTPC_PLAY;
        end
        HTPC_PLAY: begin
          if (flt.overtemp || flt.out_short) state_r <= HTPC_FAULT;
          else if (!launch_r) state_r <= HTPC_READY;
        end
        HTPC_FAULT: if (!flt.overtemp && !flt.out_short) state_r <= HTPC_IDLE;
        default:    state_r <= HTPC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: latched, cleared when condition gone and on reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      overtemp_r         <= 1'b0;
      short_fault_flag_r <= 1'b0;
    end else if (dead || soft_rst_r) begin
      overtemp_r         <= 1'b0;
      short_fault_flag_r <= 1'b0;
    end else begin
      overtemp_r         <= flt.overtemp;
      // short is only noticed while driving
      if (flt.out_short && state_r == HTPC_PLAY) begin
        short_fault_flag_r <= 1'b1;
      end else if (!flt.out_short) begin
        short_fault_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      supply_r <= 8'h00;
    end else if (state_r == HTPC_PLAY) begin
      supply_r <= supply_meas_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus watchdog: counts while a transfer is open and nothing moves
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdog_r          <= 23'h000000;
      bus_proto_rst_o <= 1'b0;
    end else if (standby || bus_idle_i || bus_activity_i) begin
      wdog_r          <= 23'h000000;
      bus_proto_rst_o <= 1'b0;
    end else if (wdog_r == 23'(WDOG_LIMIT - 1)) begin
      wdog_r          <= 23'h000000;
      bus_proto_rst_o <= 1'b1;
    end else begin
      wdog_r          <= wdog_r + 23'h000001;
      bus_proto_rst_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // noise gate: threshold steps of 2, 4, 8 counts, 0 disables
  always_comb begin
    case (cfg_r[1:0])
      2'h0:    gate_level = 8'h00;
      2'h1:    gate_level = 8'h02;
      2'h2:    gate_level = 8'h04;
      default: gate_level = 8'h08;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gated_amp_o <= 8'h00;
    end else begin
      gated_amp_o <= (input_amp_i < gate_level) ? 8'h00 : input_amp_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs and read port
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      playing_o  <= 1'b0;
      shutdown_o <= 1'b1;
    end else begin
      playing_o  <= (state_r == HTPC_PLAY) && launch_r;
      shutdown_o <= !enable_pin_i || dead || state_r == HTPC_FAULT;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (reg_rd) begin
      case (req.addr)
        STATUS_ADDR: rdata_o <= {6'h00, overtemp_r, short_fault_flag_r};
        MODE_ADDR:   rdata_o <= mode_r;
        LAUNCH_ADDR: rdata_o <= {7'h00, launch_r};
        CFG_ADDR:    rdata_o <= cfg_r;
        SUPPLY_ADDR: rdata_o <= supply_r;
        default:     rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  edge_cancel_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    trig_mode_i == TRIG_EDGE && trig_rise && launch_r && !standby && enable_pin_i && !dead && !soft_rst_r
    |=> !launch_r) else $error("edge retrigger did not cancel");
  edge_launch_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    trig_mode_i == TRIG_EDGE && trig_rise && !launch_r && !standby && enable_pin_i && !dead && !soft_rst_r
    && state_r != HTPC_FAULT |=> launch_r) else $error("edge trigger did not launch");
  edge_fall_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    trig_mode_i == TRIG_EDGE && trig_fall && launch_r && !seq_done_i && !reg_wr && !standby
    && enable_pin_i && !dead && !soft_rst_r && state_r != HTPC_FAULT |=> launch_r)
    else $error("falling edge changed flag");
  level_track_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    trig_mode_i == TRIG_LEVEL && !trig_lvl |=> !launch_r) else $error("level flag not cleared");
  standby_stop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    standby |=> !launch_r ##1 !playing_o) else $error("standby did not stop playback");
  soft_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    soft_rst_r |=> !soft_rst_r && mode_r == MODE_RESET_VAL) else $error("soft reset did not clear");
  no_access_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !enable_pin_i && wr_i |=> $stable(cfg_r) || $past(dead)) else $error("write while disabled");
  supply_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_r == HTPC_PLAY |=> supply_r == $past(supply_meas_i)) else $error("supply not sampled");
  fault_stop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    overtemp_i && state_r == HTPC_PLAY && !dead && !soft_rst_r |=> state_r == HTPC_FAULT ##1 shutdown_o)
    else $error("overtemp did not shut down");
  wdog_quiet_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    standby |=> !bus_proto_rst_o) else $error("watchdog fired in standby");
  // a held internal reset returns registers and flag to defaults at the next edge
  dead_reset_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    dead |=> mode_r == MODE_RESET_VAL && cfg_r == CFG_RESET_VAL && !launch_r)
    else $error("internal reset left state behind");
  enable_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !enable_pin_i |=> shutdown_o && !launch_r) else $error("disabled part not shut down");
  gate_block_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    input_amp_i < gate_level |=> gated_amp_o == 8'h00) else $error("noise gate passed small input");
  short_latch_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    out_short_i && state_r == HTPC_PLAY && !dead && !soft_rst_r
    |=> short_fault_flag_r && state_r == HTPC_FAULT) else $error("output short not latched");
  level_follow_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    trig_mode_i == TRIG_LEVEL && trig_lvl && !standby && enable_pin_i && !dead && !soft_rst_r
    && state_r != HTPC_FAULT |=> launch_r) else $error("level flag not raised");
  write_launch_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    trig_mode_i != TRIG_EDGE && trig_mode_i != TRIG_LEVEL && reg_wr && req.addr == LAUNCH_ADDR
    && req.wdata[0] && !standby && !dead && !soft_rst_r && state_r != HTPC_FAULT |=> launch_r)
    else $error("launch write did not set flag");
endmodule // htpc_top
`default_nettype wire

// File: htpc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module htpc_host_model #(
  parameter int MIN_HOLD = 50
) (
  // clock
  input  wire logic       sys_clk_i,
  // register port
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  input  wire logic [7:0] rdata_i,
  // pins
  output logic            enable_o,
  output logic            trig_o
);
  initial begin
    {addr_o, wdata_o, wr_o, rd_o, trig_o} = '0;
    enable_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  // released lines flip so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    {wr_o, addr_o, wdata_o} <= {1'b1, a, d};
    @(posedge sys_clk_i);
    {wr_o, addr_o, wdata_o} <= {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    {rd_o, addr_o} <= {1'b1, a};
    @(posedge sys_clk_i);
    {rd_o, addr_o} <= {1'b0, ~a};
    // data stands for the one cycle after the strobe edge; take it once settled
    #1;
    d = rdata_i;
  endtask
  // every level is held one microsecond or longer
  task automatic trig(input logic v);
    @(posedge sys_clk_i);
    trig_o <= v;
    repeat (MIN_HOLD) @(posedge sys_clk_i);
  endtask
  task automatic set_en(input logic v);
    @(posedge sys_clk_i);
    enable_o <= v;
  endtask
endmodule // htpc_host_model
`default_nettype wire

// File: htpc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module htpc_top_tb
  import htpc_pkg::*;
;
  // short watchdog keeps the stall tests brief
  localparam int WDL = 16;
  localparam logic [7:0] THR [4] = '{8'h00, 8'h02, 8'h04, 8'h08};
  logic       sys_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic [7:0] addr, wdata, rdata, gated_amp, rv, amp_e;
  logic [7:0] supply_meas = 8'h00;
  logic [7:0] input_amp   = 8'h00;
  logic [2:0] trig_mode   = 3'h0;
  logic       wr, rd, enable, trig, playing, shutdown, proto_rst;
  logic       overtemp = 1'b0, out_short = 1'b0, reg_short = 1'b0, brownout = 1'b0;
  logic       seq_done = 1'b0, bus_act = 1'b0, bus_idle = 1'b1;
  int         err_count = 0;
  int         checks = 0;
  int         cycles = 0;
  int         wd_hits = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  htpc_host_model i_host (
    .sys_clk_i(sys_clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata), .enable_o(enable), .trig_o(trig));
  htpc_top #(.WDOG_LIMIT(WDL)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .enable_pin_i(enable), .trigger_input_pin_i(trig),
    .trig_mode_i(trig_mode), .overtemp_i(overtemp), .out_short_i(out_short),
    .reg_short_i(reg_short), .brownout_i(brownout), .supply_meas_i(supply_meas),
    .input_amp_i(input_amp), .seq_done_i(seq_done), .bus_activity_i(bus_act),
    .bus_idle_i(bus_idle), .playing_o(playing), .shutdown_o(shutdown),
    .bus_proto_rst_o(proto_rst), .gated_amp_o(gated_amp));
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (proto_rst === 1'b1) wd_hits <= wd_hits + 1;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, rv);
    chk(rv, exp);
  endtask
  // sel 0 watches playback, 1 shutdown; bounded so a stuck output still reports
  task automatic wait_out(input bit sel, input logic v);
    logic s;
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk_i);
      #1;
      s = sel ? shutdown : playing;
      if (s === v) break;
    end
    chk({7'h0, s}, {7'h0, v});
  endtask
  // act high keeps the bus moving, so an open transfer is not a stall
  task automatic stall(input logic hit, input logic act);
    @(posedge sys_clk_i);
    bus_idle <= 1'b0;
    bus_act  <= act;
    wd_hits = 0;
    repeat (3 * WDL) @(posedge sys_clk_i);
    bus_idle <= 1'b1;
    bus_act  <= 1'b0;
    chk({7'h0, wd_hits != 0}, {7'h0, hit});
  endtask
  task automatic launch();
    i_host.wr(LAUNCH_ADDR, 8'h01);
    wait_out(1'b0, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rdchk(MODE_ADDR, MODE_RESET_VAL);
    rdchk(CFG_ADDR, CFG_RESET_VAL);
    stall(1'b0, 1'b0);
    i_host.wr(MODE_ADDR, 8'h00);
    stall(1'b0, 1'b1);
    stall(1'b1, 1'b0);
    launch();
    rdchk(LAUNCH_ADDR, 8'h01);
    @(posedge sys_clk_i);
    supply_meas <= 8'h5a;
    rdchk(SUPPLY_ADDR, 8'h5a);
    i_host.wr(LAUNCH_ADDR, 8'h00);
    wait_out(1'b0, 1'b0);
    // out of playback the field holds and a host write has no effect
    @(posedge sys_clk_i);
    supply_meas <= 8'hc3;
    i_host.wr(SUPPLY_ADDR, 8'h00);
    rdchk(SUPPLY_ADDR, 8'h5a);
    launch();
    @(posedge sys_clk_i);
    seq_done <= 1'b1;
    @(posedge sys_clk_i);
    seq_done <= 1'b0;
    wait_out(1'b0, 1'b0);
    rdchk(LAUNCH_ADDR, 8'h00);
    launch();
    i_host.wr(MODE_ADDR, MODE_RESET_VAL);
    wait_out(1'b0, 1'b0);
    i_host.wr(MODE_ADDR, 8'h00);
    for (int t = 0; t < 4; t++) begin
      i_host.wr(CFG_ADDR, 8'(t));
      for (int k = 0; k < 2; k++) begin
        @(posedge sys_clk_i);
        input_amp <= THR[t] - 8'(k);
        amp_e = (k == 1 && t > 0) ? 8'h00 : THR[t] - 8'(k);
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk(gated_amp, amp_e);
      end
    end
    launch();
    i_host.wr(MODE_ADDR, 8'h80);
    wait_out(1'b0, 1'b0);
    rdchk(MODE_ADDR, MODE_RESET_VAL);
    rdchk(CFG_ADDR, CFG_RESET_VAL);
    i_host.wr(MODE_ADDR, 8'h00);
    // edge mode: a second rise cancels, the fall is ignored
    @(posedge sys_clk_i);
    trig_mode <= TRIG_EDGE;
    i_host.trig(1'b1);
    wait_out(1'b0, 1'b1);
    i_host.trig(1'b0);
    wait_out(1'b0, 1'b1);
    rdchk(LAUNCH_ADDR, 8'h01);
    i_host.trig(1'b1);
    wait_out(1'b0, 1'b0);
    rdchk(LAUNCH_ADDR, 8'h00);
    i_host.trig(1'b0);
    @(posedge sys_clk_i);
    trig_mode <= TRIG_LEVEL;
    i_host.trig(1'b1);
    wait_out(1'b0, 1'b1);
    rdchk(LAUNCH_ADDR, 8'h01);
    i_host.trig(1'b0);
    wait_out(1'b0, 1'b0);
    rdchk(LAUNCH_ADDR, 8'h00);
    @(posedge sys_clk_i);
    trig_mode <= TRIG_INTERNAL;
    // disabled part keeps its registers and ignores access
    i_host.wr(CFG_ADDR, 8'h01);
    i_host.set_en(1'b0);
    wait_out(1'b1, 1'b1);
    i_host.wr(CFG_ADDR, 8'h02);
    rdchk(CFG_ADDR, 8'h00);
    i_host.set_en(1'b1);
    wait_out(1'b1, 1'b0);
    rdchk(CFG_ADDR, 8'h01);
    // f 0 overtemperature, f 1 output short, each during playback
    for (int f = 0; f < 2; f++) begin
      launch();
      @(posedge sys_clk_i);
      {overtemp, out_short} <= (f == 0) ? 2'b10 : 2'b01;
      wait_out(1'b1, 1'b1);
      wait_out(1'b0, 1'b0);
      rdchk(STATUS_ADDR, 8'(1 << ((f == 0) ? STAT_OVERTEMP_BIT : STAT_SHORT_BIT)));
      rdchk(LAUNCH_ADDR, 8'h00);
      @(posedge sys_clk_i);
      {overtemp, out_short} <= 2'b00;
      wait_out(1'b1, 1'b0);
      wait_out(1'b0, 1'b0);
      rdchk(STATUS_ADDR, 8'h00);
    end
    for (int f = 0; f < 2; f++) begin
      i_host.wr(MODE_ADDR, 8'h00);
      i_host.wr(CFG_ADDR, 8'h02);
      @(posedge sys_clk_i);
      {reg_short, brownout} <= (f == 0) ? 2'b10 : 2'b01;
      wait_out(1'b1, 1'b1);
      @(posedge sys_clk_i);
      {reg_short, brownout} <= 2'b00;
      rdchk(MODE_ADDR, MODE_RESET_VAL);
      rdchk(CFG_ADDR, CFG_RESET_VAL);
    end
    print_verdict();
  end
endmodule // htpc_top_tb
`default_nettype wire
